// ==== common/sws_pkg.sv ====
// Shared constants and types of the sleep and wake sequencer.
package sws_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: one 1 ms tick, then 10 ms and 100 ms prescaled ticks.
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned TICK_PERIOD_PS = 1000000000;
  localparam int unsigned MS_TICK_CYCLES = TICK_PERIOD_PS / CLK_PERIOD_PS;
  localparam int unsigned TEN_MS_DIV     = 10;
  localparam int unsigned HUNDRED_MS_DIV = 10;
  localparam logic [15:0] PEEK_MS        = 16'h0002;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices on the configuration port.
  localparam logic [2:0] IDX_PIN4_HOLD   = 3'h0;
  localparam logic [2:0] IDX_PWM_HOLD    = 3'h1;
  localparam logic [2:0] IDX_MODE        = 3'h2;
  localparam logic [2:0] IDX_OPTIONS     = 3'h3;
  localparam logic [2:0] IDX_IND_COUNT   = 3'h4;
  localparam logic [2:0] IDX_SLEEP_TIME  = 3'h5;
  localparam logic [2:0] IDX_WAKE_TIME   = 3'h6;
  localparam logic [2:0] IDX_HOST_DELAY  = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and limits.
  localparam logic [15:0] RST_PIN4_HOLD  = 16'h0000;
  localparam logic [15:0] RST_PWM_HOLD   = 16'h00FF;
  localparam logic [7:0]  RST_MODE       = 8'h00;
  localparam logic [15:0] RST_OPTIONS    = 16'h0002;
  localparam logic [15:0] RST_IND_COUNT  = 16'h0001;
  localparam logic [31:0] RST_SLEEP_TIME = 32'h0000012C;
  localparam logic [31:0] RST_WAKE_TIME  = 32'h00000D08;
  localparam logic [15:0] RST_HOST_DELAY = 16'h0000;
  localparam logic [31:0] MAX_HOLD       = 32'h00001770;
  localparam logic [31:0] MAX_OPTIONS    = 32'h0000013E;
  localparam logic [31:0] MAX_IND_COUNT  = 32'h0000FFFF;
  localparam logic [31:0] MAX_SLEEP_TIME = 32'h0015F900;
  localparam logic [31:0] MAX_WAKE_TIME  = 32'h0036EE80;
  localparam logic [31:0] MAX_HOST_DELAY = 32'h0000FFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Sleep mode codes and option bit positions.
  localparam logic [7:0] MODE_NONE      = 8'h00;
  localparam logic [7:0] MODE_PIN       = 8'h01;
  localparam logic [7:0] MODE_CYCLIC    = 8'h04;
  localparam logic [7:0] MODE_PIN_WAKE  = 8'h05;
  localparam logic [7:0] MODE_SUPPORT   = 8'h07;
  localparam logic [7:0] MODE_SYNC      = 8'h08;
  localparam int unsigned OPT_ALWAYS_COORD = 0;
  localparam int unsigned OPT_NEVER_COORD  = 1;
  localparam int unsigned OPT_STATUS_MSG   = 2;
  localparam int unsigned OPT_NO_EARLY     = 3;
  localparam int unsigned OPT_NODE_EQUAL   = 4;
  localparam int unsigned OPT_NO_RAPID     = 5;
  localparam int unsigned OPT_FULL_WAKE    = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic        wr;
    logic [2:0]  idx;
    logic [31:0] data;
  } sws_cfg_wr_t;

  typedef struct packed {
    logic always_coord;
    logic never_coord;
    logic status_msg;
    logic no_early_wake;
    logic node_equal;
    logic no_rapid_deploy;
  } sws_sync_opt_t;

  typedef enum logic [1:0] {
    S_AWAKE = 2'b00,
    S_FULL  = 2'b01,
    S_DOZE  = 2'b11,
    S_PEEK  = 2'b10
  } sws_state_t;

endpackage

// ==== logic/sws_tick_gen.sv ====
// Divider that makes 1 ms, 10 ms and 100 ms tick enables.
`timescale 1ns/10ps
module sws_tick_gen
  import sws_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Tick enables.
  output logic      tick_1ms_o,
  output logic      tick_10ms_o,
  output logic      tick_100ms_o
);

  logic [31:0] div_r;
  logic [3:0]  ten_r;
  logic [3:0]  hun_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_r      <= 32'h00000000;
      tick_1ms_o <= 1'b0;
    end else if (div_r == 32'(TICK_CYCLES - 1)) begin
      div_r      <= 32'h00000000;
      tick_1ms_o <= 1'b1;
    end else begin
      div_r      <= div_r + 32'h00000001;
      tick_1ms_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ten_r       <= 4'h0;
      hun_r       <= 4'h0;
      tick_10ms_o  <= 1'b0;
      tick_100ms_o <= 1'b0;
    end else begin
      tick_10ms_o  <= 1'b0;
      tick_100ms_o <= 1'b0;
      if (div_r == 32'(TICK_CYCLES - 1)) begin
        if (ten_r == 4'(TEN_MS_DIV - 1)) begin
          ten_r      <= 4'h0;
          tick_10ms_o <= 1'b1;
          if (hun_r == 4'(HUNDRED_MS_DIV - 1)) begin
            hun_r        <= 4'h0;
            tick_100ms_o <= 1'b1;
          end else begin
            hun_r <= hun_r + 4'h1;
          end
        end else begin
          ten_r <= ten_r + 4'h1;
        end
      end
    end
  end

endmodule

// ==== logic/sws_sequencer.sv ====
// Sleep and wake sequencer with output hold timeouts.
// Operation
// - Pin four holds a driven value for its timeout, then reverts; zero: none.
// - Each enabled PWM output goes low when PWM timeout expires; zero disables.
// - Mode codes 0,1,4,5,7,8 decode to sleep behaviours; others unused.
// - Pin-wake cyclic mode cycles while request pin asserted, wakes on release.
// - Asynchronous cyclic mode sleeps, then briefly peeks for activity.
// - Sleep support mode stays awake yet speaks synchronized sleep traffic.
// - Synchronized modes refused when baud setting is zero.
// - Options above limit, or bits zero and one both set, are rejected.
// - Synchronized option bits zero to five steer coordinator and status.
// - Option bit eight keeps every asynchronous wake-up for full wake time.
// - Indicator asserts on every Nth asynchronous wake-up, or when a peek sees data.
// - Silent wake-ups check for data; data wakes fully, else sleep again.
// - Indicator cycle count is ignored in synchronized sleep.
// - Each cycle sleeps for sleep period in 10 ms units.
// - Asynchronous wake lasts wake time in ms after serial or radio data.
// - Synchronized wake time raised to required minimum, capped at limit.
// - Host wake delay holds output after waking; serial input ends it.
// - Synchronized sleep shortened by host delay; wake covers delay plus unicast.
`timescale 1ns/10ps
module sws_sequencer
  import sws_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  // Configuration port.
  input  wire sws_cfg_wr_t    cfg_i,
  input  wire logic [2:0]     cfg_rd_idx_i,
  output logic [31:0]         cfg_rdata_o,
  output logic                cfg_err_o,
  // Host pin and activity.
  input  wire logic           sleep_request_pin_i,
  input  wire logic           serial_rx_i,
  input  wire logic           radio_rx_i,
  // Radio settings.
  input  wire logic [3:0]     baud_setting_i,
  input  wire logic [31:0]    sync_min_wake_i,
  input  wire logic [15:0]    unicast_time_i,
  // Pin four.
  input  wire logic           pin4_load_i,
  input  wire logic           pin4_value_i,
  input  wire logic           pin4_default_i,
  output logic                digital_pin_four_o,
  // PWM outputs.
  input  wire logic [1:0]     pwm_enabled_i,
  input  wire logic           pwm_load_i,
  input  wire logic [9:0]     pwm_zero_duty_i,
  input  wire logic [9:0]     pwm_one_duty_i,
  output logic [9:0]          pwm_output_zero_o,
  output logic [9:0]          pwm_output_one_o,
  // Sleep status.
  output logic                awake_o,
  output logic                wake_indicator_o,
  output logic                host_tx_enable_o,
  output logic                sync_traffic_o,
  output sws_sync_opt_t       sync_opt_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Ticks.
  logic tick_1ms;
  logic tick_10ms;
  logic tick_100ms;

  sws_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .tick_1ms_o   (tick_1ms),
    .tick_10ms_o  (tick_10ms),
    .tick_100ms_o (tick_100ms)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers and write checks.
  logic [15:0] pin_four_hold_timeout_r;
  logic [15:0] pwm_hold_timeout_r;
  logic [7:0]  sleep_mode_select_r;
  logic [15:0] sleep_option_bits_r;
  logic [15:0] wake_indicator_cycle_count_r;
  logic [31:0] sleep_period_r;
  logic [31:0] wake_period_r;
  logic [15:0] host_wake_delay_r;
  logic        wr_ok;
  logic        mode_ok;
  logic [7:0]  wmode;

  assign wmode = cfg_i.data[7:0];

  always_comb begin
    mode_ok = 1'b0;
    if (cfg_i.data[31:8] == 24'h000000) begin
      unique case (wmode)
        MODE_NONE, MODE_PIN, MODE_CYCLIC, MODE_PIN_WAKE:
          mode_ok = 1'b1;
        MODE_SUPPORT, MODE_SYNC:
          mode_ok = (baud_setting_i != 4'h0);
        default:
          mode_ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    wr_ok = 1'b0;
    unique case (cfg_i.idx)
      IDX_PIN4_HOLD, IDX_PWM_HOLD:
        wr_ok = (cfg_i.data <= MAX_HOLD);
      IDX_MODE:
        wr_ok = mode_ok;
      IDX_OPTIONS:
        wr_ok = (cfg_i.data <= MAX_OPTIONS) &&
                !(cfg_i.data[OPT_ALWAYS_COORD] &&
                  cfg_i.data[OPT_NEVER_COORD]);
      IDX_IND_COUNT:
        wr_ok = (cfg_i.data != 32'h0) && (cfg_i.data <= MAX_IND_COUNT);
      IDX_SLEEP_TIME:
        wr_ok = (cfg_i.data != 32'h0) && (cfg_i.data <= MAX_SLEEP_TIME);
      IDX_WAKE_TIME:
        wr_ok = (cfg_i.data != 32'h0) && (cfg_i.data <= MAX_WAKE_TIME);
      IDX_HOST_DELAY:
        wr_ok = (cfg_i.data <= MAX_HOST_DELAY);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_four_hold_timeout_r      <= RST_PIN4_HOLD;
      pwm_hold_timeout_r           <= RST_PWM_HOLD;
      sleep_mode_select_r          <= RST_MODE;
      sleep_option_bits_r          <= RST_OPTIONS;
      wake_indicator_cycle_count_r <= RST_IND_COUNT;
      sleep_period_r               <= RST_SLEEP_TIME;
      wake_period_r                <= RST_WAKE_TIME;
      host_wake_delay_r            <= RST_HOST_DELAY;
      cfg_err_o                    <= 1'b0;
    end else begin
      cfg_err_o <= cfg_i.wr && !wr_ok;
      if (cfg_i.wr && wr_ok) begin
        unique case (cfg_i.idx)
          IDX_PIN4_HOLD:  pin_four_hold_timeout_r      <= cfg_i.data[15:0];
          IDX_PWM_HOLD:   pwm_hold_timeout_r           <= cfg_i.data[15:0];
          IDX_MODE:       sleep_mode_select_r          <= wmode;
          IDX_OPTIONS:    sleep_option_bits_r          <= cfg_i.data[15:0];
          IDX_IND_COUNT:  wake_indicator_cycle_count_r <= cfg_i.data[15:0];
          IDX_SLEEP_TIME: sleep_period_r               <= cfg_i.data;
          IDX_WAKE_TIME:  wake_period_r                <= cfg_i.data;
          IDX_HOST_DELAY: host_wake_delay_r            <= cfg_i.data[15:0];
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_rdata_o <= 32'h00000000;
    end else begin
      unique case (cfg_rd_idx_i)
        IDX_PIN4_HOLD:  cfg_rdata_o <= {16'h0000, pin_four_hold_timeout_r};
        IDX_PWM_HOLD:   cfg_rdata_o <= {16'h0000, pwm_hold_timeout_r};
        IDX_MODE:       cfg_rdata_o <= {24'h000000, sleep_mode_select_r};
        IDX_OPTIONS:    cfg_rdata_o <= {16'h0000, sleep_option_bits_r};
        IDX_IND_COUNT:
          cfg_rdata_o <= {16'h0000, wake_indicator_cycle_count_r};
        IDX_SLEEP_TIME: cfg_rdata_o <= sleep_period_r;
        IDX_WAKE_TIME:  cfg_rdata_o <= wake_period_r;
        IDX_HOST_DELAY: cfg_rdata_o <= {16'h0000, host_wake_delay_r};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and synchronized options.
  logic is_pin;
  logic is_cyc;
  logic is_pwake;
  logic is_sync;
  logic is_async;

  assign is_pin   = (sleep_mode_select_r == MODE_PIN);
  assign is_cyc   = (sleep_mode_select_r == MODE_CYCLIC);
  assign is_pwake = (sleep_mode_select_r == MODE_PIN_WAKE);
  assign is_sync  = (sleep_mode_select_r == MODE_SYNC);
  assign is_async = is_cyc || is_pwake;
  assign sync_traffic_o = is_sync ||
                          (sleep_mode_select_r == MODE_SUPPORT);

  always_comb begin
    sync_opt_o.always_coord    = sleep_option_bits_r[OPT_ALWAYS_COORD];
    sync_opt_o.never_coord     = sleep_option_bits_r[OPT_NEVER_COORD];
    sync_opt_o.status_msg      = sleep_option_bits_r[OPT_STATUS_MSG];
    sync_opt_o.no_early_wake   = sleep_option_bits_r[OPT_NO_EARLY];
    sync_opt_o.node_equal      = sleep_option_bits_r[OPT_NODE_EQUAL];
    sync_opt_o.no_rapid_deploy = sleep_option_bits_r[OPT_NO_RAPID];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and activity.
  logic sreq_meta_r;
  logic sreq_r;
  logic activity;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sreq_meta_r <= 1'b0;
      sreq_r      <= 1'b0;
    end else begin
      sreq_meta_r <= sleep_request_pin_i;
      sreq_r      <= sreq_meta_r;
    end
  end

  assign activity = serial_rx_i || radio_rx_i;

  ////////////////////////////////////////////////////////////////////////////
  // Period arithmetic.
  logic [31:0] sleep_ms;
  logic [31:0] sync_sleep_ms;
  logic [31:0] need_wake;
  logic [31:0] sync_wake_ms;
  logic [31:0] floor_wake;

  assign sleep_ms = 32'(sleep_period_r * 32'd10);
  assign sync_sleep_ms = (sleep_ms > {16'h0000, host_wake_delay_r}) ?
                         sleep_ms - {16'h0000, host_wake_delay_r} :
                         32'h00000001;
  assign need_wake = {16'h0000, host_wake_delay_r} +
                     {16'h0000, unicast_time_i};
  assign floor_wake = (sync_min_wake_i > need_wake) ?
                      sync_min_wake_i : need_wake;

  always_comb begin
    sync_wake_ms = (wake_period_r > floor_wake) ? wake_period_r
                                                : floor_wake;
    if (sync_wake_ms > MAX_WAKE_TIME) begin
      sync_wake_ms = MAX_WAKE_TIME;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep state machine.
  sws_state_t  state_r;
  sws_state_t  state_nxt;
  logic [31:0] timer_r;
  logic [31:0] timer_nxt;
  logic [15:0] wakes_r;
  logic [15:0] wakes_nxt;
  logic        ind_nxt;
  logic        cyc_run;
  logic        expired;

  assign cyc_run = is_cyc || (is_pwake && sreq_r) || is_sync;
  assign expired = (timer_r <= 32'h00000001) && tick_1ms;

  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    wakes_nxt = wakes_r;
    ind_nxt   = wake_indicator_o;
    if (tick_1ms && timer_r != 32'h0) begin
      timer_nxt = timer_r - 32'h00000001;
    end
    unique case (state_r)
      S_AWAKE: begin
        ind_nxt = 1'b1;
        if (is_pin && sreq_r) begin
          state_nxt = S_DOZE;
          ind_nxt   = 1'b0;
          timer_nxt = 32'h0;
        end else if (cyc_run) begin
          state_nxt = S_DOZE;
          ind_nxt   = 1'b0;
          timer_nxt = is_sync ? sync_sleep_ms : sleep_ms;
          wakes_nxt = 16'h0000;
        end
      end
      S_DOZE: begin
        ind_nxt = 1'b0;
        if (is_pin) begin
          if (!sreq_r) begin
            state_nxt = S_AWAKE;
            ind_nxt   = 1'b1;
          end
        end else if (!cyc_run) begin
          state_nxt = S_AWAKE;
          ind_nxt   = 1'b1;
        end else if (expired) begin
          if (is_sync) begin
            state_nxt = S_FULL;
            ind_nxt   = 1'b1;
            timer_nxt = sync_wake_ms;
          end else if (wakes_r + 16'h0001 >=
                       wake_indicator_cycle_count_r) begin
            state_nxt = S_FULL;
            ind_nxt   = 1'b1;
            wakes_nxt = 16'h0000;
            timer_nxt = wake_period_r;
          end else begin
            state_nxt = S_PEEK;
            wakes_nxt = wakes_r + 16'h0001;
            timer_nxt = sleep_option_bits_r[OPT_FULL_WAKE] ?
                        wake_period_r :
                        {16'h0000, PEEK_MS};
          end
        end
      end
      S_PEEK: begin
        if (!cyc_run) begin
          state_nxt = S_AWAKE;
          ind_nxt   = 1'b1;
        end else if (activity) begin
          state_nxt = S_FULL;
          ind_nxt   = 1'b1;
          timer_nxt = wake_period_r;
        end else if (expired) begin
          state_nxt = S_DOZE;
          timer_nxt = sleep_ms;
        end
      end
      S_FULL: begin
        ind_nxt = 1'b1;
        if (!cyc_run) begin
          state_nxt = S_AWAKE;
        end else if (is_async && activity) begin
          timer_nxt = wake_period_r;
        end else if (expired) begin
          state_nxt = S_DOZE;
          ind_nxt   = 1'b0;
          timer_nxt = is_sync ? sync_sleep_ms : sleep_ms;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r          <= S_AWAKE;
      timer_r          <= 32'h00000000;
      wakes_r          <= 16'h0000;
      wake_indicator_o <= 1'b1;
    end else begin
      state_r          <= state_nxt;
      timer_r          <= timer_nxt;
      wakes_r          <= wakes_nxt;
      wake_indicator_o <= ind_nxt;
    end
  end

  assign awake_o = (state_r != S_DOZE);

  ////////////////////////////////////////////////////////////////////////////
  // Host wake delay.
  logic [15:0] host_dly_r;
  logic        woke;

  assign woke = (state_r == S_DOZE || state_r == S_PEEK) &&
                (state_nxt == S_FULL || state_nxt == S_AWAKE);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      host_dly_r <= 16'h0000;
    end else if (woke) begin
      host_dly_r <= host_wake_delay_r;
    end else if (serial_rx_i || state_r == S_DOZE) begin
      host_dly_r <= 16'h0000;
    end else if (tick_1ms && host_dly_r != 16'h0000) begin
      host_dly_r <= host_dly_r - 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      host_tx_enable_o <= 1'b1;
    end else begin
      host_tx_enable_o <= ind_nxt && !woke &&
                          (host_dly_r == 16'h0000 || serial_rx_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin four hold timeout.
  logic [15:0] pin4_cnt_r;
  logic        pin4_hold_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin4_cnt_r         <= 16'h0000;
      pin4_hold_r        <= 1'b0;
      digital_pin_four_o <= 1'b0;
    end else if (pin4_load_i) begin
      pin4_cnt_r         <= pin_four_hold_timeout_r;
      pin4_hold_r        <= 1'b1;
      digital_pin_four_o <= pin4_value_i;
    end else if (!pin4_hold_r) begin
      digital_pin_four_o <= pin4_default_i;
    end else if (tick_100ms && pin4_cnt_r != 16'h0000) begin
      pin4_cnt_r <= pin4_cnt_r - 16'h0001;
      if (pin4_cnt_r == 16'h0001) begin
        pin4_hold_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM hold timeout.
  logic [15:0] pwm_cnt_r;
  logic        pwm_dead_r;
  logic [9:0]  duty_in [2];
  logic [9:0]  duty_out [2];

  assign duty_in[0] = pwm_zero_duty_i;
  assign duty_in[1] = pwm_one_duty_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pwm_cnt_r  <= 16'h0000;
      pwm_dead_r <= 1'b0;
    end else if (pwm_load_i) begin
      pwm_cnt_r  <= pwm_hold_timeout_r;
      pwm_dead_r <= 1'b0;
    end else if (tick_100ms && pwm_cnt_r != 16'h0000) begin
      pwm_cnt_r <= pwm_cnt_r - 16'h0001;
      if (pwm_cnt_r == 16'h0001) begin
        pwm_dead_r <= 1'b1;
      end
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_pwm
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        duty_out[g] <= 10'h000;
      end else if (pwm_enabled_i[g] && pwm_dead_r && !pwm_load_i) begin
        duty_out[g] <= 10'h000;
      end else begin
        duty_out[g] <= duty_in[g];
      end
    end
  end

  assign pwm_output_zero_o = duty_out[0];
  assign pwm_output_one_o  = duty_out[1];

endmodule

// ==== tb/sws_host_model.sv ====
// Host model that drives the sleep request pin.
`timescale 1ns/10ps
module sws_host_model (
  // Clock and request.
  input  wire logic clk_i,
  input  wire logic want_sleep_i,
  // Pin to the sequencer.
  output logic      sleep_request_pin_o
);
  always @(negedge clk_i) sleep_request_pin_o <= want_sleep_i;
endmodule

// ==== tb/sws_seq_chk.sv ====
// Port checker of the sleep and wake sequencer.
`timescale 1ns/10ps
module sws_seq_chk
  import sws_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_TICK_CYCLES
) (
  // Clock, reset and inputs.
  input wire logic          clk_i,
  input wire logic          rst_n_i,
  input wire sws_cfg_wr_t   cfg_i,
  input wire logic [3:0]    baud_setting_i,
  input wire logic          pin4_load_i,
  input wire logic          pin4_value_i,
  // Outputs.
  input wire logic          cfg_err_o,
  input wire logic          digital_pin_four_o,
  input wire logic          sync_traffic_o,
  input wire sws_sync_opt_t sync_opt_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_err_cause: assert property (cfg_err_o |-> $past(cfg_i.wr))
    else $error("Error flag without a write.");
  a_bad_mode: assert property (cfg_i.wr && cfg_i.idx == IDX_MODE &&
    (cfg_i.data > 32'h8 || cfg_i.data[3:0] inside {4'h2, 4'h3, 4'h6})
    |=> cfg_err_o) else $error("Unused mode accepted.");
  a_both_coord: assert property (cfg_i.wr && cfg_i.idx == IDX_OPTIONS
    && cfg_i.data[1:0] == 2'b11 |=> cfg_err_o)
    else $error("Both coordinator bits accepted.");
  a_sync_baud: assert property (cfg_i.wr && cfg_i.idx == IDX_MODE &&
    cfg_i.data == 32'h8 && baud_setting_i == 4'h0 |=> cfg_err_o)
    else $error("Synchronized mode accepted at baud zero.");
  a_sync_rise: assert property ($rose(sync_traffic_o) |->
    $past(cfg_i.wr) && $past(cfg_i.idx) == IDX_MODE)
    else $error("Sync traffic rose without a mode write.");
  a_opt_reflect: assert property (cfg_i.wr && cfg_i.idx == IDX_OPTIONS
    && cfg_i.data <= MAX_OPTIONS && cfg_i.data[1:0] != 2'b11 |=>
    sync_opt_o.always_coord == $past(cfg_i.data[0]) &&
    sync_opt_o.no_rapid_deploy == $past(cfg_i.data[5]))
    else $error("Option bits not reflected.");
  a_pin4_load: assert property (pin4_load_i |=>
    digital_pin_four_o == $past(pin4_value_i))
    else $error("Pin four did not take the loaded value.");
  a_count_zero: assert property (cfg_i.wr && cfg_i.idx == IDX_IND_COUNT
    && cfg_i.data == 32'h0 |-> ##1 cfg_err_o)
    else $error("Zero cycle count accepted.");
endmodule

bind sws_sequencer sws_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_inst (
  .clk_i, .rst_n_i, .cfg_i, .baud_setting_i, .pin4_load_i, .pin4_value_i,
  .cfg_err_o, .digital_pin_four_o, .sync_traffic_o, .sync_opt_o);

// ==== tb/sws_sequencer_bench.sv ====
// Self-checking bench of the sleep and wake sequencer.
`timescale 1ns/10ps
module sws_sequencer_bench;
  import sws_pkg::*;
  localparam int unsigned TC = 20;
  sws_cfg_wr_t cfg;
  logic        clk_i, rst_n_i, err, want, pin_rq, radio, p4_load, p4_val;
  logic        p4_o, pwm_load, awake, ind, tx, ser;
  logic [1:0]  pwm_en;
  logic [2:0]  rd_idx;
  logic [3:0]  baud;
  logic [9:0]  d0, d1, pw0, pw1;
  logic [31:0] rdata, r;
  logic [31:0] shd [8];
  int          fails, compares, seed;

  sws_sequencer #(.TICK_CYCLES(TC)) sws_sequencer_inst (
    .clk_i, .rst_n_i, .cfg_i(cfg), .cfg_rd_idx_i(rd_idx), .cfg_rdata_o(rdata),
    .cfg_err_o(err), .sleep_request_pin_i(pin_rq), .serial_rx_i(ser),
    .radio_rx_i(radio), .baud_setting_i(baud), .sync_min_wake_i(32'h1),
    .unicast_time_i(16'h1), .pin4_load_i(p4_load), .pin4_value_i(p4_val),
    .pin4_default_i(~p4_val), .digital_pin_four_o(p4_o),
    .pwm_enabled_i(pwm_en), .pwm_load_i(pwm_load), .pwm_zero_duty_i(d0),
    .pwm_one_duty_i(d1), .pwm_output_zero_o(pw0), .pwm_output_one_o(pw1),
    .awake_o(awake), .wake_indicator_o(ind), .host_tx_enable_o(tx),
    .sync_traffic_o(), .sync_opt_o());
  sws_host_model sws_host_model_inst (.clk_i, .want_sleep_i(want),
    .sleep_request_pin_o(pin_rq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_flag(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [31:0] lim(input logic [2:0] i);
    case (i)
      IDX_PIN4_HOLD, IDX_PWM_HOLD: return MAX_HOLD;
      IDX_MODE: return 32'(MODE_SYNC);
      IDX_OPTIONS: return MAX_OPTIONS;
      IDX_IND_COUNT: return MAX_IND_COUNT;
      IDX_SLEEP_TIME: return MAX_SLEEP_TIME;
      IDX_WAKE_TIME: return MAX_WAKE_TIME;
      default: return MAX_HOST_DELAY;
    endcase
  endfunction
  function automatic logic exp_err(input logic [2:0] i, input logic [31:0] d);
    if (i == IDX_MODE)
      return !(d inside {0, 1, 4, 5} || (d inside {7, 8} && baud != 4'h0));
    if (i == IDX_OPTIONS) return d > MAX_OPTIONS || d[1:0] == 2'b11;
    if (i inside {IDX_IND_COUNT, IDX_SLEEP_TIME, IDX_WAKE_TIME} && d == 0)
      return 1'b1;
    return d > lim(i);
  endfunction
  task automatic wr(input logic [2:0] i, input logic [31:0] d);
    logic e;
    e = exp_err(i, d);
    cfg = '{1'b1, i, d};
    rd_idx = i;
    @(negedge clk_i);
    cfg.wr = 1'b0;
    chk_flag(err, e);
    if (!e) shd[i] = d;
    @(negedge clk_i);
    chk_word(rdata, shd[i]);
  endtask
  task automatic wait_awake(input logic v, input int n);
    logic hit;
    hit = 1'b0;
    repeat (n) begin
      @(negedge clk_i);
      if (awake === v) hit = 1'b1;
      if (hit) break;
    end
    chk_flag(hit, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  initial begin
    seed = 32'h97560F90;
    {cfg, rd_idx, baud, want, radio, ser, p4_load, p4_val, pwm_load} = '0;
    {fails, compares} = '0;
    pwm_en = 2'b11;
    {d0, d1} = {10'h155, 10'h2AA};
    shd = '{32'(RST_PIN4_HOLD), 32'(RST_PWM_HOLD), 32'(RST_MODE),
      32'(RST_OPTIONS), 32'(RST_IND_COUNT), RST_SLEEP_TIME, RST_WAKE_TIME,
      32'(RST_HOST_DELAY)};
    rst_n_i = 1'b0;
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    foreach (shd[i]) begin
      rd_idx = 3'(i);
      repeat (2) @(negedge clk_i);
      chk_word(rdata, shd[i]);
    end
    foreach (shd[i]) begin
      wr(3'(i), 32'h0);
      wr(3'(i), lim(3'(i)));
      wr(3'(i), lim(3'(i)) + 32'h1);
    end
    baud = 4'h1;
    for (int m = 0; m < 10; m++) wr(IDX_MODE, 32'(m));
    wr(IDX_OPTIONS, 32'h3);
    wr(IDX_MODE, 32'h0);
    wr(IDX_SLEEP_TIME, 32'h1);
    wr(IDX_WAKE_TIME, 32'h5);
    wr(IDX_IND_COUNT, 32'h2);
    wr(IDX_OPTIONS, 32'h2);
    wr(IDX_MODE, 32'(MODE_CYCLIC));
    wait_awake(1'b0, 4);
    repeat (8*TC) @(negedge clk_i);
    chk_flag(awake, 1'b0);
    wait_awake(1'b1, 3*TC);
    repeat (TC/2) @(negedge clk_i);
    chk_flag(ind, 1'b0);
    wait_awake(1'b0, 3*TC);
    wait_awake(1'b1, 11*TC);
    repeat (2) @(negedge clk_i);
    chk_flag(ind, 1'b1);
    chk_flag(tx, 1'b0);
    ser = 1'b1;
    @(negedge clk_i);
    ser = 1'b0;
    @(negedge clk_i);
    chk_flag(tx, 1'b1);
    repeat (3*TC) @(negedge clk_i);
    chk_flag(awake, 1'b1);
    wait_awake(1'b0, 3*TC);
    wait_awake(1'b1, 11*TC);
    radio = 1'b1;
    @(negedge clk_i);
    radio = 1'b0;
    repeat (3*TC) @(negedge clk_i);
    chk_flag(ind, 1'b1);
    want = 1'b1;
    wr(IDX_MODE, 32'(MODE_PIN_WAKE));
    wait_awake(1'b0, 8);
    want = 1'b0;
    wait_awake(1'b1, 6);
    repeat (12*TC) @(negedge clk_i);
    chk_flag(awake, 1'b1);
    wr(IDX_MODE, 32'(MODE_SUPPORT));
    repeat (12*TC) @(negedge clk_i);
    chk_flag(awake, 1'b1);
    wr(IDX_PIN4_HOLD, 32'h2);
    wr(IDX_PWM_HOLD, 32'h2);
    {p4_val, p4_load, pwm_load} = 3'b111;
    @(negedge clk_i);
    {p4_load, pwm_load} = 2'b00;
    repeat (90*TC) @(negedge clk_i);
    chk_flag(p4_o, 1'b1);
    chk_word(32'(pw1), 32'(d1));
    repeat (120*TC) @(negedge clk_i);
    chk_flag(p4_o, 1'b0);
    chk_word(32'({pw0, pw1}), 32'h0);
    repeat (40) begin
      r = $random(seed);
      baud = r[11:8];
      wr(r[2:0], $random(seed) >> r[7:3]);
    end
    print_verdict();
  end
endmodule
